// File: rtl/bma_pkg.sv
package bma_pkg;

    localparam int unsigned BMA_XLEN          = 32;
    localparam int unsigned BMA_IMM_W         = 5;
    localparam int unsigned BMA_LEN_LSB       = 5;
    localparam int unsigned BMA_POS_LSB       = 0;
    localparam logic [31:0] BMA_RESULT_RESET  = 32'h0000_0000;
    localparam int unsigned BMA_EXT_ENABLE    = 1;
    localparam int unsigned BMA_EXEC_CYCLES   = 1;
    localparam logic [1:0]  BMA_RADIX_BIT1    = 2'h0;
    localparam logic [1:0]  BMA_RADIX_BIT2    = 2'h1;
    localparam logic [1:0]  BMA_RADIX_BIT3    = 2'h2;
    localparam logic [1:0]  BMA_RADIX_ALIAS   = 2'h3;

    typedef enum logic [2:0] {
        BMA_OP_SIGNED_FIELD_EXTRACT   = 3'b000,
        BMA_OP_UNSIGNED_FIELD_EXTRACT = 3'b001,
        BMA_OP_FIELD_INSERT           = 3'b010,
        BMA_OP_FIELD_CLEAR            = 3'b011,
        BMA_OP_FIELD_SET              = 3'b100,
        BMA_OP_GROUP_BIT_REVERSE      = 3'b101
    } bma_op_type;

    typedef struct packed {
        logic        valid;
        bma_op_type  op;
        logic        use_reg;
        logic [31:0] rs1;
        logic [31:0] rs2;
        logic [4:0]  length_or_radix_imm;
        logic [4:0]  position_or_shift_imm;
    } bma_req_type;

    typedef struct packed {
        logic        valid;
        logic        illegal;
        logic [31:0] result;
    } bma_rsp_type;

endpackage

// File: rtl/bma_bit_reverse.sv
`timescale 1ns/100ps
module bma_bit_reverse
    import bma_pkg::*;
(
    input  wire logic [31:0] operand,
    input  wire logic [4:0]  position_or_shift_imm,
    input  wire logic [1:0]  length_or_radix_imm,
    output logic      [31:0] result
);
    logic [31:0] shifted;
    logic [31:0] rev1;
    logic [31:0] rev2;
    logic [31:0] rev3;

    // Upper bits are thrown away so only the low 32-shift bits take part
    assign shifted = operand << position_or_shift_imm;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_bit
            assign rev1[gi] = shifted[31 - gi];
        end
        for (gi = 0; gi < 16; gi++) begin : g_pair
            assign rev2[2*gi +: 2] = shifted[30 - 2*gi +: 2];
        end
        // Ten triples; bits 1:0 of the shifted word fall off the bottom
        for (gi = 0; gi < 10; gi++) begin : g_tri
            assign rev3[3*gi +: 3] = shifted[29 - 3*gi +: 3];
        end
    endgenerate
    assign rev3[31:30] = 2'h0;

    assign result = (length_or_radix_imm == BMA_RADIX_BIT2) ? rev2 :
                    (length_or_radix_imm == BMA_RADIX_BIT3) ? rev3 :
                    rev1;
endmodule

// File: rtl/bma_bit_manip_alu.sv
`timescale 1ns/100ps
module bma_bit_manip_alu
    import bma_pkg::*;
#(
    parameter int unsigned CUSTOM_EXT_ENABLE_PARAM = BMA_EXT_ENABLE
)(
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire bma_pkg::bma_req_type req,
    output bma_pkg::bma_rsp_type      rsp
);
    import bma_pkg::*;

    logic [4:0]  field_len;
    logic [4:0]  field_pos;
    logic [5:0]  field_top;
    logic [31:0] len_mask;
    logic [31:0] field_mask;
    logic [31:0] extract_raw;
    logic [31:0] extract_sext;
    logic [31:0] extract_zext;
    logic [31:0] insert_val;
    logic [31:0] reverse_val;
    logic [31:0] result_next;
    logic        ext_on;
    logic        sign_bit;
    bma_rsp_type rsp_reg;
    bma_rsp_type rsp_next;

    // Ones in bits [n:0]
    function automatic logic [31:0] low_ones(input logic [4:0] n);
        low_ones = 32'hffff_ffff >> (5'd31 - n);
    endfunction

    assign ext_on    = (CUSTOM_EXT_ENABLE_PARAM == 1);
    assign field_len = req.use_reg ? req.rs2[BMA_LEN_LSB +: BMA_IMM_W]
                                   : req.length_or_radix_imm;
    assign field_pos = req.use_reg ? req.rs2[BMA_POS_LSB +: BMA_IMM_W]
                                   : req.position_or_shift_imm;
    // Field top is clipped at bit 31, so long fields simply run off the word
    assign field_top = ({1'b0, field_len} + {1'b0, field_pos} > 6'd31) ? 6'd31
                       : {1'b0, field_len} + {1'b0, field_pos};
    assign len_mask   = low_ones(field_len);
    assign field_mask = len_mask << field_pos;

    assign extract_raw  = req.rs1 >> field_pos;
    assign extract_zext = extract_raw & low_ones(5'(field_top - {1'b0, field_pos}));
    assign sign_bit     = req.rs1[field_top[4:0]];
    assign extract_sext = extract_zext |
                          (sign_bit ? ~low_ones(5'(field_top - {1'b0, field_pos})) : 32'h0);
    assign insert_val   = (req.rs1 & ~field_mask) | ((req.rs1 << field_pos) & field_mask);

    bma_bit_reverse u_reverse (
        .operand               (req.rs1),
        .position_or_shift_imm (req.position_or_shift_imm),
        .length_or_radix_imm   (req.length_or_radix_imm[1:0]),
        .result                (reverse_val)
    );

    always_comb begin
        result_next = BMA_RESULT_RESET;
        unique case (req.op)
            BMA_OP_SIGNED_FIELD_EXTRACT:   result_next = extract_sext;
            BMA_OP_UNSIGNED_FIELD_EXTRACT: result_next = extract_zext;
            BMA_OP_FIELD_INSERT:           result_next = insert_val;
            BMA_OP_FIELD_CLEAR:            result_next = req.rs1 & ~field_mask;
            BMA_OP_FIELD_SET:              result_next = req.rs1 | field_mask;
            BMA_OP_GROUP_BIT_REVERSE:      result_next = reverse_val;
            default:                       result_next = BMA_RESULT_RESET;
        endcase
    end

    assign rsp_next.valid   = req.valid;
    assign rsp_next.illegal = req.valid & ~ext_on;
    assign rsp_next.result  = ext_on ? result_next : BMA_RESULT_RESET;

    // Registered so the writeback sees a flop output at the end of execute
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end
    assign rsp = rsp_reg;

    property p_set_result;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && req.op == BMA_OP_FIELD_SET && ext_on)
            |=> (rsp.result == ($past(req.rs1) | $past(field_mask)));
    endproperty
    a_set_result: assert property (p_set_result) else $error("set result wrong");

    property p_clear_result;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && req.op == BMA_OP_FIELD_CLEAR && ext_on)
            |=> ((rsp.result & $past(field_mask)) == 32'h0);
    endproperty
    a_clear_result: assert property (p_clear_result) else $error("clear left ones");

    property p_outside_kept;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && (req.op == BMA_OP_FIELD_CLEAR || req.op == BMA_OP_FIELD_SET
            || req.op == BMA_OP_FIELD_INSERT))
            |=> ((rsp.result & ~$past(field_mask)) == ($past(req.rs1) & ~$past(field_mask)));
    endproperty
    a_outside_kept: assert property (p_outside_kept) else $error("outside bits changed");

    property p_zext_top;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_UNSIGNED_FIELD_EXTRACT && field_top < 6'd31)
            |=> (rsp.result[31] == 1'b0);
    endproperty
    a_zext_top: assert property (p_zext_top) else $error("zext top bit set");

    property p_sext_sign;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_SIGNED_FIELD_EXTRACT)
            |=> (rsp.result[31] == $past(sign_bit));
    endproperty
    a_sext_sign: assert property (p_sext_sign) else $error("sign bit wrong");

    property p_insert_low;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_FIELD_INSERT && field_pos == 5'd0)
            |=> ((rsp.result & $past(len_mask)) == ($past(req.rs1) & $past(len_mask)));
    endproperty
    a_insert_low: assert property (p_insert_low) else $error("insert field wrong");

    // Any nonzero shift pushes a zero into bit 0 first, so bit 31 must then read zero
    property p_rev_bit;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_GROUP_BIT_REVERSE
            && req.length_or_radix_imm[1:0] != BMA_RADIX_BIT2
            && req.length_or_radix_imm[1:0] != BMA_RADIX_BIT3)
            |=> (rsp.result[31] == ($past(req.rs1[0])
                && $past(req.position_or_shift_imm) == 5'd0));
    endproperty
    a_rev_bit: assert property (p_rev_bit) else $error("bit mirror wrong");

    property p_rev_tri_top;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_GROUP_BIT_REVERSE
            && req.length_or_radix_imm[1:0] == BMA_RADIX_BIT3)
            |=> (rsp.result[31:30] == 2'h0);
    endproperty
    a_rev_tri_top: assert property (p_rev_tri_top) else $error("triple top not zero");

    property p_rev_pair;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_GROUP_BIT_REVERSE
            && req.length_or_radix_imm[1:0] == BMA_RADIX_BIT2 && req.position_or_shift_imm == 5'd0)
            |=> (rsp.result[31:30] == $past(req.rs1[1:0]));
    endproperty
    a_rev_pair: assert property (p_rev_pair) else $error("pair swap wrong");

    property p_illegal;
        @(posedge mclk) disable iff (!nrst)
        req.valid |=> (rsp.valid && rsp.illegal == !ext_on);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal flag wrong");

    property p_zext_clean;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_UNSIGNED_FIELD_EXTRACT)
            |=> ((rsp.result & ~$past(len_mask)) == 32'h0);
    endproperty
    a_zext_clean: assert property (p_zext_clean) else $error("zext upper bits set");

    // A clipped field is narrower than len+1, so the fill may reach below bit len
    property p_sext_fill;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_SIGNED_FIELD_EXTRACT)
            |=> ($past(sign_bit) ? ((rsp.result | $past(len_mask)) == 32'hffff_ffff)
                                 : ((rsp.result & ~$past(len_mask)) == 32'h0));
    endproperty
    a_sext_fill: assert property (p_sext_fill) else $error("sign fill wrong");

    property p_rev_tri_low;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_GROUP_BIT_REVERSE
            && req.length_or_radix_imm[1:0] == BMA_RADIX_BIT3 && req.position_or_shift_imm == 5'd0)
            |=> (rsp.result[2:0] == $past(req.rs1[31:29]));
    endproperty
    a_rev_tri_low: assert property (p_rev_tri_low) else $error("triple swap wrong");

    property p_rev_pair_low;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && ext_on && req.op == BMA_OP_GROUP_BIT_REVERSE
            && req.length_or_radix_imm[1:0] == BMA_RADIX_BIT2 && req.position_or_shift_imm == 5'd0)
            |=> (rsp.result[1:0] == $past(req.rs1[31:30]));
    endproperty
    a_rev_pair_low: assert property (p_rev_pair_low) else $error("pair low wrong");

    property p_off_zero;
        @(posedge mclk) disable iff (!nrst)
        (req.valid && !ext_on) |=> (rsp.result == 32'h0);
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("result not zero");

    c_extract: cover property (@(posedge mclk) disable iff (!nrst)
        req.valid && req.op == BMA_OP_SIGNED_FIELD_EXTRACT && sign_bit);
    c_insert: cover property (@(posedge mclk) disable iff (!nrst)
        req.valid && req.op == BMA_OP_FIELD_INSERT && field_top == 6'd31);
    c_rev3: cover property (@(posedge mclk) disable iff (!nrst)
        req.valid && req.op == BMA_OP_GROUP_BIT_REVERSE && req.length_or_radix_imm[1:0] == 2'h2);
    c_rev_alias: cover property (@(posedge mclk) disable iff (!nrst)
        req.valid && req.op == BMA_OP_GROUP_BIT_REVERSE
        && req.length_or_radix_imm[1:0] == BMA_RADIX_ALIAS);
    c_off: cover property (@(posedge mclk) disable iff (!nrst) req.valid && !ext_on);
endmodule

// File: test/bma_core_model.sv
`timescale 1ns/100ps
module bma_core_model
    import bma_pkg::*;
(
    input  wire logic                 mclk,
    output bma_pkg::bma_req_type      req,
    input  wire bma_pkg::bma_rsp_type rsp
);
    initial req = '0;
    // Decode side: present at +1 ns, take the answer 1 ns after the next edge
    task automatic issue(input bma_op_type op, input logic ur,
                         input logic [31:0] a, input logic [31:0] b,
                         input logic [4:0] len, input logic [4:0] pos,
                         output bma_rsp_type got);
        req = '{1'b1, op, ur, a, b, len, pos};
        @(posedge mclk);
        #1;
        got = rsp;
    endtask
    task automatic idle(output bma_rsp_type got);
        req.valid = 1'b0;
        @(posedge mclk);
        #1;
        got = rsp;
    endtask
endmodule

// File: test/bma_bit_manip_alu_tb.sv
`timescale 1ns/100ps
module bma_bit_manip_alu_tb;
    import bma_pkg::*;
    logic        mclk;
    logic        nrst;
    bma_req_type req;
    bma_rsp_type rsp;
    bma_rsp_type rsp_off;
    bma_rsp_type got;
    int          err_count;
    int          checks_done;

    bma_bit_manip_alu u_bma_bit_manip_alu (.mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp));
    // Second copy with the extension turned off shares the same requests
    bma_bit_manip_alu #(.CUSTOM_EXT_ENABLE_PARAM(0)) u_bma_bit_manip_alu_off (
        .mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp_off));
    bma_core_model u_bma_core_model (.mclk(mclk), .req(req), .rsp(rsp));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] fmask(input int len, input int pos);
        for (int i = 0; i < 32; i++) fmask[i] = (i >= pos) && (i <= len + pos);
    endfunction

    function automatic logic [31:0] ref_field(input int op, input logic [31:0] a,
                                              input int len, input int pos);
        logic [31:0] m;
        m = fmask(len, pos);
        case (op)
            0: ref_field = ((a & m) >> pos) | (a[(len + pos > 31) ? 31 : len + pos] ?
                           ~(m >> pos) : 32'h0000_0000);
            1: ref_field = (a & m) >> pos;
            2: ref_field = (a & ~m) | ((a << pos) & m);
            3: ref_field = a & ~m;
            default: ref_field = a | m;
        endcase
    endfunction

    function automatic logic [31:0] ref_rev(input logic [31:0] a, input int sh, input int r);
        logic [31:0] s;
        s = a << sh;
        for (int i = 0; i < 32; i++) begin
            if (r == 1) ref_rev[i] = s[30 - 2 * (i / 2) + i % 2];
            else if (r == 2) ref_rev[i] = (i < 30) ? s[29 - 3 * (i / 3) + i % 3] : 1'b0;
            else ref_rev[i] = s[31 - i];
        end
    endfunction

    task automatic t_field();
        int          lens[4] = '{3, 31, 0, 9};
        int          poss[4] = '{4, 0, 31, 27};
        logic [31:0] a;
        logic [4:0]  li;
        logic [4:0]  pi;
        logic [31:0] exp_v;
        for (int op = 0; op < 5; op++) begin
            for (int k = 0; k < 4; k++) begin
                a = 32'hc64a_5933 ^ (32'h1 << (op * 5 + k));
                // Register form gets misleading immediates so the select is exercised
                li = k[0] ? ~lens[k][4:0] : lens[k][4:0];
                pi = k[0] ? ~poss[k][4:0] : poss[k][4:0];
                u_bma_core_model.issue(bma_op_type'(op), k[0], a,
                    {22'h2a_aaaa, lens[k][4:0], poss[k][4:0]}, li, pi, got);
                exp_v = ref_field(op, a, lens[k], poss[k]);
                check(got, {2'b10, exp_v});
                check(rsp_off, {2'b11, 32'h0000_0000});
            end
        end
        $display("field test done");
    endtask

    task automatic t_rev();
        int          shs[3] = '{4, 0, 31};
        logic [31:0] a;
        u_bma_core_model.issue(BMA_OP_GROUP_BIT_REVERSE, 1'b0, 32'hc64a_5933, 32'h0,
                               5'h02, 5'h04, got);
        check(got, {2'b10, 32'h216b_244b});
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                a = (k == 0) ? 32'hc64a_5933 : (32'h9e37_79b9 ^ r);
                u_bma_core_model.issue(BMA_OP_GROUP_BIT_REVERSE, 1'b1, a, 32'hffff_ffff,
                                       {3'h5, r[1:0]}, shs[k][4:0], got);
                check(got, {2'b10, ref_rev(a, shs[k], r)});
            end
        end
        $display("reverse test done");
    endtask

    task automatic t_idle();
        u_bma_core_model.idle(got);
        check({got.valid, got.illegal, 32'h0}, 34'h0);
        check({rsp_off.valid, rsp_off.illegal, 32'h0}, 34'h0);
        $display("idle test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        summarize();
    end

    initial begin
        err_count = 0;
        checks_done = 0;
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check(rsp, 34'h0);
        nrst = 1'b1;
        t_field();
        t_rev();
        t_idle();
        summarize();
    end
endmodule
